// file: pkg/dsf_params.svh
`ifndef DSF_PARAMS_SVH
`define DSF_PARAMS_SVH

// Register indices; byte address is four times the index
`define DSF_IDX_MODE 18'h312b8
`define DSF_IDX_CAPS 18'h312b9
`define DSF_IDX_DIGCNT 18'h312ba
`define DSF_IDX_STATUS 18'h312bb
`define DSF_IDX_COUNT 18'h312bc

// Conversion mode codes
`define DSF_MODE_PASS 32'h0000_0000
`define DSF_MODE_W12 32'h0000_0004
`define DSF_MODE_W13 32'h0000_0020
`define DSF_MODE_W14 32'h0000_0008
`define DSF_MODE_W15 32'h0000_0010

// Capability mask: every supported widening code
`define DSF_CAPS_VALUE 32'h0000_003c

// Shift distances per conversion code
`define DSF_SHIFT_W12 3'h4
`define DSF_SHIFT_W13 3'h3
`define DSF_SHIFT_W14 3'h2
`define DSF_SHIFT_W15 3'h1
`define DSF_SHIFT_NONE 3'h0

// Embedded digital bit count limit and reset values
`define DSF_DIGCNT_MAX 3'h4
`define DSF_DIGCNT_RESET 3'h0
`define DSF_MODE_RESET 32'h0000_0000

// Status register fields
`define DSF_STAT_REJECT_BIT 0
`define DSF_STAT_DIGACT_BIT 1

`endif

// file: pkg/dsf_pkg.sv
package dsf_pkg;

    // Bus slave handshake states, one-hot
    typedef enum logic [2:0] {
        DSF_IDLE = 3'b001,
        DSF_ACCESS = 3'b010,
        DSF_RESP = 3'b100
    } dsf_bus_state_e;

    // One replay sample word, two's complement
    typedef logic signed [15:0] dsf_sample_t;

endpackage

// file: src/dsf_shifter.sv
// Left shift of a sample word, zero fill from below
module dsf_shifter (
    input wire logic [15:0] word_in,
    input wire logic [2:0] amount,
    output logic [15:0] word_out
);

    // Bits above bit 15 fall off; vacated low bits become zero
    assign word_out = word_in << amount;

endmodule

// file: src/dsf_top.sv
// Overview of operation
// - Samples are signed sixteen bit words
// - Top k bits become channel digital outputs
// - Analog field shifted up to DAC MSB
// - Analog field stays two's complement, LSB k
// - One global read/write conversion mode setting
// - Read-only capability mask of supported modes
// - Code 0h passes words unchanged
// - Code 4h shifts up by four
// - Code 20h shifts up by three
// - Code 8h shifts up by two
// - Code 10h shifts up by one
// - Shift ignores content and channel
// - Passthrough plus digital enable splits bits
// - Widening conversion discards embedded digital bits
//
// The APB interface to the registers was chosen for this implementation.
`include "dsf_params.svh"

module dsf_top (
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Sample stream from the replay buffer
    input wire logic sample_valid,
    input wire logic [15:0] sample_in,
    // Formatted stream toward the DAC
    output logic dac_valid,
    output logic [15:0] dac_data,
    // Embedded digital outputs
    output logic multipurpose_line_0,
    output logic multipurpose_line_1,
    output logic multipurpose_line_2,
    output logic multipurpose_line_3
);

    // Bus handshake state
    dsf_pkg::dsf_bus_state_e state_q;
    dsf_pkg::dsf_bus_state_e state_d;

    // Software visible registers
    logic [31:0] mode_q; // Conversion mode
    logic [2:0] digcnt_q; // Embedded digital bit count
    logic reject_q; // Sticky rejected-write flag
    logic [31:0] count_q; // Samples formatted since reset

    // Bus answer registers
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // Stream output registers
    logic dac_valid_q;
    logic [15:0] dac_data_q;
    logic [3:0] lines_q;

    // Address decode
    wire [17:0] word_index = paddr[19:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_mode = aligned && (word_index == `DSF_IDX_MODE);
    wire hit_caps = aligned && (word_index == `DSF_IDX_CAPS);
    wire hit_digcnt = aligned && (word_index == `DSF_IDX_DIGCNT);
    wire hit_status = aligned && (word_index == `DSF_IDX_STATUS);
    wire hit_count = aligned && (word_index == `DSF_IDX_COUNT);
    wire hit_any = hit_mode | hit_caps | hit_digcnt | hit_status | hit_count;

    // Full-word strobe; partial writes would leave a mode half-written
    wire full_strobe = (pstrb == 4'hf);

    // Access phase seen for the first time
    wire access_now = (state_q == dsf_pkg::DSF_ACCESS);
    wire wr_now = access_now && pwrite;
    wire rd_now = access_now && !pwrite;

    wire code_known = (pwdata == `DSF_MODE_PASS) ||
                      (pwdata == `DSF_MODE_W12) ||
                      (pwdata == `DSF_MODE_W13) ||
                      (pwdata == `DSF_MODE_W14) ||
                      (pwdata == `DSF_MODE_W15);
    wire code_capable = ((pwdata & ~`DSF_CAPS_VALUE) == 32'h0000_0000);
    wire mode_ok = code_known && code_capable && full_strobe;

    // Digital bit count above the limit is refused
    wire digcnt_ok = (pwdata[31:3] == 29'h0000_0000) &&
                     (pwdata[2:0] <= `DSF_DIGCNT_MAX) && full_strobe;

    // Write accept strobes
    wire wr_mode = wr_now && hit_mode && mode_ok;
    wire wr_digcnt = wr_now && hit_digcnt && digcnt_ok;
    wire wr_status = wr_now && hit_status;

    // Refused writes: bad code, bad count, read-only target, unmapped
    wire wr_bad_mode = wr_now && hit_mode && !mode_ok;
    wire wr_bad_cnt = wr_now && hit_digcnt && !digcnt_ok;
    wire wr_ro = wr_now && (hit_caps || hit_count);
    wire wr_refused = wr_bad_mode || wr_bad_cnt || wr_ro;
    wire unmapped = access_now && !hit_any;

    // Status clear request, write one to clear
    wire reject_clr = wr_status && full_strobe && pwdata[`DSF_STAT_REJECT_BIT];

    // Conversion active when any widening code is selected
    wire conv_active = (mode_q != `DSF_MODE_PASS);
    // split only in passthrough with digital enabled
    wire split_active = !conv_active && (digcnt_q != 3'h0);

    // Status word seen by software
    wire [31:0] status_word = {30'h0000_0000, split_active, reject_q};

    // Read data selection
    wire [31:0] rd_data = hit_mode ? mode_q :
                          hit_caps ? `DSF_CAPS_VALUE :
                          hit_digcnt ? {29'h0000_0000, digcnt_q} :
                          hit_status ? status_word :
                          hit_count ? count_q :
                          32'h0000_0000;

    wire [2:0] conv_shift = (mode_q == `DSF_MODE_W12) ? `DSF_SHIFT_W12 :
                            (mode_q == `DSF_MODE_W13) ? `DSF_SHIFT_W13 :
                            (mode_q == `DSF_MODE_W14) ? `DSF_SHIFT_W14 :
                            (mode_q == `DSF_MODE_W15) ? `DSF_SHIFT_W15 :
                            `DSF_SHIFT_NONE;

    // analog field moved up by k
    wire [2:0] shift_amount = split_active ? digcnt_q : conv_shift;

    // word taken as signed two's complement
    dsf_pkg::dsf_sample_t sample_word;
    assign sample_word = sample_in;

    // Shifted word
    logic [15:0] shifted;

    dsf_shifter u_shift (
        .word_in(sample_word),
        .amount(shift_amount),
        .word_out(shifted)
    );

    wire [3:0] top_bits = {sample_in[12], sample_in[13], sample_in[14], sample_in[15]};
    // Mask of enabled lines, line 0 takes D15
    wire [3:0] line_mask = (digcnt_q == 3'h1) ? 4'h1 :
                           (digcnt_q == 3'h2) ? 4'h3 :
                           (digcnt_q == 3'h3) ? 4'h7 :
                           (digcnt_q == 3'h4) ? 4'hf :
                           4'h0;
    wire [3:0] lines_next = split_active ? (top_bits & line_mask) : 4'h0;

    // sign bit lands on bit 15
    wire [15:0] dac_next = shifted;

    // Bus state sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            // Setup seen: answer in the following access phase
            dsf_pkg::DSF_IDLE: begin
                if (psel && !penable) begin
                    state_d = dsf_pkg::DSF_ACCESS;
                end
            end
            // Decide and raise pready for one cycle
            dsf_pkg::DSF_ACCESS: begin
                state_d = dsf_pkg::DSF_RESP;
            end
            // Master releases or starts a new setup
            dsf_pkg::DSF_RESP: begin
                if (psel && !penable) begin
                    state_d = dsf_pkg::DSF_ACCESS;
                end else begin
                    state_d = dsf_pkg::DSF_IDLE;
                end
            end
            // Illegal code recovers to idle
            default: begin
                state_d = dsf_pkg::DSF_IDLE;
            end
        endcase
    end

    // Bus state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= dsf_pkg::DSF_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Bus answer, registered so pready is a flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= access_now;
            // Read data only changes with a read answer
            if (rd_now) begin
                prdata_q <= rd_data;
            end
            pslverr_q <= access_now && (unmapped || wr_refused);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= `DSF_MODE_RESET;
        end else if (wr_mode) begin
            mode_q <= pwdata;
        end
    end

    // Digital bit count register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            digcnt_q <= `DSF_DIGCNT_RESET;
        end else if (wr_digcnt) begin
            digcnt_q <= pwdata[2:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reject_q <= 1'b0;
        end else if (wr_bad_mode || wr_bad_cnt) begin
            reject_q <= 1'b1;
        end else if (reject_clr) begin
            reject_q <= 1'b0;
        end
    end

    // Sample counter, wraps; lets software see the stream move
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= 32'h0000_0000;
        end else if (sample_valid) begin
            count_q <= count_q + 32'h0000_0001;
        end
    end

    // Stream valid, one cycle latency
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dac_valid_q <= 1'b0;
        end else begin
            dac_valid_q <= sample_valid;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dac_data_q <= 16'h0000;
            lines_q <= 4'h0;
        end else if (sample_valid) begin
            dac_data_q <= dac_next;
            lines_q <= lines_next;
        end
    end

    // Mode changes take effect on the next sample; words in flight keep the old format
    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign dac_valid = dac_valid_q;
    assign dac_data = dac_data_q;
    assign multipurpose_line_0 = lines_q[0];
    assign multipurpose_line_1 = lines_q[1];
    assign multipurpose_line_2 = lines_q[2];
    assign multipurpose_line_3 = lines_q[3];

endmodule

// file: verification/dsf_replay_buf.sv
// Replay buffer model feeding one word per valid cycle
module dsf_replay_buf (
    input wire logic clock,
    input wire logic rst,
    input wire logic slow,
    output logic sample_valid,
    output logic [15:0] sample_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] q[$]; // Words waiting for replay
    logic gap_q; // Idle cycle marker for slow mode
    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask
    // Idle bus shows inverted word so stale data never looks valid
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sample_valid <= 1'b0;
            sample_in <= 16'h0000;
            gap_q <= 1'b0;
        end else if (q.size() != 0 && !(slow && gap_q)) begin
            sample_valid <= 1'b1;
            sample_in <= q.pop_front();
            gap_q <= 1'b1;
        end else begin
            sample_valid <= 1'b0;
            sample_in <= ~sample_in;
            gap_q <= 1'b0;
        end
    end
endmodule

// file: verification/dsf_top_sva.sv
module dsf_top_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic sample_valid,
    input wire logic [15:0] sample_in,
    input wire logic dac_valid,
    input wire logic [15:0] dac_data,
    input wire logic multipurpose_line_0,
    input wire logic multipurpose_line_1,
    input wire logic multipurpose_line_2,
    input wire logic multipurpose_line_3
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Bus request and its one wait state answer
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; !pready ##1 pready; endsequence
    bus_wait_a: assert property (setup_s |=> answer_s)
        else $error("bus answer not on second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Read request aimed at the capability mask
    sequence caps_req_s; psel && !penable && !pwrite && paddr == 20'hc4ae4; endsequence
    caps_read_a: assert property (caps_req_s |=> ##1 prdata == 32'h3c)
        else $error("capability mask wrong");
    valid_delay_a: assert property (sample_valid |=> dac_valid)
        else $error("sample lost");
    idle_hold_a: assert property (!sample_valid |=> !dac_valid && $stable(dac_data))
        else $error("output moved without sample");
    lines_hold_a: assert property (!sample_valid |=>
        $stable({multipurpose_line_3, multipurpose_line_2, multipurpose_line_1,
        multipurpose_line_0}))
        else $error("digital lines moved without sample");
    zero_fill_a: assert property (multipurpose_line_0 |-> dac_data[0] == 1'b0)
        else $error("vacated bit not zero");
    field_lsb_a: assert property (multipurpose_line_3 |-> dac_data[3:0] == 4'h0)
        else $error("analog field misplaced");
endmodule
bind dsf_top dsf_top_sva chk (.*);

// file: verification/tb_dac_sample_word_formatter.sv
module tb_dac_sample_word_formatter;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, sv, dv, slow;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] si, dd;
    logic [3:0] ln;
    logic e;
    logic [3:0] ps; // Byte strobes driven to the bus
    logic [19:0] got[$]; // Formatted words seen at the output
    int n_mismatch = 0;
    int tests_run = 0;
    dsf_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(ps), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sample_valid(sv), .sample_in(si), .dac_valid(dv), .dac_data(dd),
        .multipurpose_line_0(ln[0]), .multipurpose_line_1(ln[1]),
        .multipurpose_line_2(ln[2]), .multipurpose_line_3(ln[3]));
    dsf_replay_buf src (.clock(clock), .rst(rst), .slow(slow), .sample_valid(sv), .sample_in(si));
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    // Output monitor
    always @(posedge clock) begin
        if (dv === 1'b1) got.push_back({ln, dd});
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gv);
        tests_run++;
        if (gv !== ex) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, gv);
            n_mismatch++;
        end
    endtask
    task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Hold the request until pready is sampled high
        @(posedge clock);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clock);
            n++;
        end
        if (n >= 50) n_mismatch++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected word: shift by code, else split k digital bits
    function automatic logic [19:0] fmt(logic [31:0] c, int k, logic [15:0] x);
        logic [3:0] l;
        int s;
        l = 0;
        s = c == 4 ? 4 : c == 32'h20 ? 3 : c == 8 ? 2 : c == 32'h10 ? 1 : 0;
        if (c != 0) return {4'h0, x << s};
        for (int i = 0; i < k; i++) l[i] = x[15-i];
        return {l, x << k};
    endfunction
    task automatic take(input logic [31:0] c, input int k, input logic [15:0] x);
        int n;
        n = 0;
        while (got.size() == 0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (got.size() == 0) chk("dac timeout", 1, 0);
        else chk("dac word", fmt(c, k, x), got.pop_front());
    endtask
    // Register map, refused writes and the sticky reject flag
    task t_regs;
        apb(0, 20'hc4ae4, 0);
        chk("caps", 32'h3c, r);
        apb(0, 20'hc4ae0, 0);
        chk("mode reset", 0, r);
        apb(1, 20'hc4ae4, 0);
        chk("caps write err", 1, e);
        apb(1, 20'hc4ae0, 3);
        chk("bad mode err", 1, e);
        apb(0, 20'hc4ae0, 0);
        chk("mode kept", 0, r);
        apb(0, 20'hc4aec, 0);
        chk("reject flag set", 1, r);
        apb(1, 20'hc4aec, 1);
        chk("reject clear err", 0, e);
        apb(0, 20'hc4aec, 0);
        chk("reject flag clear", 0, r);
        // Partial strobe must not leave a half-written mode
        ps <= 4'h1;
        apb(1, 20'hc4ae0, 4);
        chk("partial write err", 1, e);
        ps <= 4'hf;
        apb(0, 20'hc4ae0, 0);
        chk("mode after partial", 0, r);
        apb(1, 20'hc4ae8, 5);
        chk("digcnt limit err", 1, e);
        apb(0, 20'hc4ae8, 0);
        chk("digcnt kept", 0, r);
        apb(1, 20'hc4aec, 1);
        apb(0, 20'hc4b40, 0);
        chk("unmapped err", 1, e);
    endtask
    // Every widening code, back-to-back words, split count left set
    task t_convert;
        logic [31:0] cd[4];
        cd = '{32'h4, 32'h20, 32'h8, 32'h10};
        apb(1, 20'hc4ae8, 2);
        for (int i = 0; i < 4; i++) begin
            apb(1, 20'hc4ae0, cd[i]);
            apb(0, 20'hc4ae0, 0);
            chk("mode readback", cd[i], r);
            apb(0, 20'hc4aec, 0);
            chk("split off in conversion", 0, r);
            src.push(16'h9ab7);
            src.push(16'h7fff);
            take(cd[i], 2, 16'h9ab7);
            take(cd[i], 2, 16'h7fff);
        end
    endtask
    // Passthrough with zero to four embedded digital bits, slow source
    task t_split;
        slow <= 1;
        apb(1, 20'hc4ae0, 0);
        for (int k = 0; k < 5; k++) begin
            apb(1, 20'hc4ae8, k);
            apb(0, 20'hc4aec, 0);
            chk("split flag", (k != 0) ? 32'h2 : 32'h0, r);
            src.push(16'hb5a3);
            src.push(16'h4c3d);
            take(0, k, 16'hb5a3);
            take(0, k, 16'h4c3d);
        end
    endtask
    // Eight words converted plus ten split words have passed
    task t_count;
        apb(0, 20'hc4af0, 0);
        chk("sample count", 18, r);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 20'h00000;
        pwdata = 32'h0000_0000;
        ps = 4'hf;
        slow = 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_regs;
        t_convert;
        t_split;
        t_count;
        close_out;
    end
    initial begin
        #200000;
        n_mismatch++;
        close_out;
    end
endmodule
